//--- include/tone_pkg.sv
package tone_pkg;

  // clock and sample timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BASE_RATE_HZ = 8000;
  localparam int unsigned FSK_RATE_HZ  = 24000;
  localparam int unsigned BASE_DIV     = CLK_HZ / BASE_RATE_HZ;
  localparam int unsigned FSK_DIV      = CLK_HZ / FSK_RATE_HZ;
  localparam int unsigned TICK_US_X8   = 1000;

  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned NUM_GEN  = 2;
  localparam int unsigned GEN_A    = 0;
  localparam int unsigned GEN_B    = 1;

  // direct register byte addresses
  localparam logic [7:0] ADDR_IRQ_PEND  = 8'h12;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h15;
  localparam logic [7:0] ADDR_IND_LO    = 8'h1C;
  localparam logic [7:0] ADDR_IND_HI    = 8'h1D;
  localparam logic [7:0] ADDR_IND_WADDR = 8'h1E;
  localparam logic [7:0] ADDR_IND_RADDR = 8'h1F;
  localparam logic [7:0] ADDR_FSK_DATA  = 8'h34;
  localparam logic [7:0] ADDR_FSK_MODE  = 8'h6C;
  localparam logic [7:0] ADDR_CTRL    [NUM_GEN] = '{8'h20, 8'h21};
  localparam logic [7:0] ADDR_ON_LO   [NUM_GEN] = '{8'h24, 8'h28};
  localparam logic [7:0] ADDR_ON_HI   [NUM_GEN] = '{8'h25, 8'h29};
  localparam logic [7:0] ADDR_OFF_LO  [NUM_GEN] = '{8'h26, 8'h2A};
  localparam logic [7:0] ADDR_OFF_HI  [NUM_GEN] = '{8'h27, 8'h2B};

  // indirect register addresses
  localparam logic [7:0] IND_FREQ  [NUM_GEN] = '{8'h0D, 8'h10};
  localparam logic [7:0] IND_AMP   [NUM_GEN] = '{8'h0E, 8'h11};
  localparam logic [7:0] IND_PHASE [NUM_GEN] = '{8'h0F, 8'h12};
  localparam logic [7:0] IND_MARK_FREQ   = 8'h63;
  localparam logic [7:0] IND_MARK_AMP    = 8'h64;
  localparam logic [7:0] IND_MARK_PHASE  = 8'h65;
  localparam logic [7:0] IND_SPACE_FREQ  = 8'h66;
  localparam logic [7:0] IND_SPACE_AMP   = 8'h67;
  localparam logic [7:0] IND_SPACE_PHASE = 8'h68;

  // control register fields
  localparam int unsigned CTRL_RX_BIT   = 0;
  localparam int unsigned CTRL_TX_BIT   = 1;
  localparam int unsigned CTRL_RUN      = 2;
  localparam int unsigned CTRL_OFF_EN   = 3;
  localparam int unsigned CTRL_ON_EN    = 4;
  localparam int unsigned CTRL_ZC       = 5;
  localparam int unsigned CTRL_REFRESH  = 6;
  localparam int unsigned CTRL_LIVE     = 7;
  localparam logic [7:0]  CTRL_WMASK_A  = 8'h7F;
  localparam logic [7:0]  CTRL_WMASK_B  = 8'h3F;
  localparam int unsigned FSK_MODE_BIT  = 6;
  localparam int unsigned FSK_LEVEL_BIT = 0;

  // interrupt bit positions
  localparam int unsigned IRQ_ON  [NUM_GEN] = '{0, 2};
  localparam int unsigned IRQ_OFF [NUM_GEN] = '{1, 3};
  localparam int unsigned IRQ_W   = 4;

  // fixed point
  localparam int unsigned COEF_SHIFT = 14;

  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_ON        = 2'b01,
    ST_ZERO_WAIT = 2'b10,
    ST_OFF       = 2'b11
  } cadence_e;

endpackage : tone_pkg

//--- logic/dual_tone_cadence_generator.sv
`timescale 1ns/100ps
module dual_tone_cadence_generator #(
  parameter int unsigned BASE_DIV = tone_pkg::BASE_DIV,
  parameter int unsigned FSK_DIV  = tone_pkg::FSK_DIV
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // interrupt
  output logic             irq,
  // audio paths
  output logic      [15:0] rx_tone,
  output logic      [15:0] tx_tone
);

  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    hi = 34'sh0_7FFF;
    lo = -34'sh0_8000;
    if (v > hi) begin
      sat16 = 16'sh7FFF;
    end else if (v < lo) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic signed [15:0] resonate(
    input logic signed [15:0] c,
    input logic signed [15:0] y1,
    input logic signed [15:0] y2
  );
    logic signed [31:0] prod;
    logic signed [33:0] acc;
    prod = c * y1;
    acc = (34'(prod) >>> tone_pkg::COEF_SHIFT) - 34'(y2);
    resonate = sat16(acc);
  endfunction : resonate

  logic [7:0]  ctrl       [tone_pkg::NUM_GEN];
  logic [15:0] on_time    [tone_pkg::NUM_GEN];
  logic [15:0] off_time   [tone_pkg::NUM_GEN];
  logic [15:0] freq_coef  [tone_pkg::NUM_GEN];
  logic [15:0] amp_coef   [tone_pkg::NUM_GEN];
  logic [15:0] phase_coef [tone_pkg::NUM_GEN];
  logic [15:0] mark_freq;
  logic [15:0] mark_amp;
  logic [15:0] mark_phase;
  logic [15:0] space_freq;
  logic [15:0] space_amp;
  logic [15:0] space_phase;
  logic [15:0] ind_data;
  logic [tone_pkg::IRQ_W-1:0] irq_pend;
  logic [tone_pkg::IRQ_W-1:0] irq_en;
  logic [tone_pkg::IRQ_W-1:0] irq_set;
  logic        enhanced_fsk_on;
  logic        fsk_level;
  logic [15:0] base_cnt;
  logic [15:0] fsk_cnt;
  logic        base_tick;
  logic        fsk_tick;
  logic        fast_mode;

  tone_pkg::cadence_e state [tone_pkg::NUM_GEN];
  logic [15:0]        count      [tone_pkg::NUM_GEN];
  logic signed [15:0] y1         [tone_pkg::NUM_GEN];
  logic signed [15:0] y2         [tone_pkg::NUM_GEN];
  logic signed [15:0] wfreq      [tone_pkg::NUM_GEN];
  logic signed [15:0] sample     [tone_pkg::NUM_GEN];
  logic               tick       [tone_pkg::NUM_GEN];
  logic               on_expire  [tone_pkg::NUM_GEN];
  logic               off_expire [tone_pkg::NUM_GEN];
  logic               end_burst  [tone_pkg::NUM_GEN];

  // sample-rate dividers
  always_ff @(posedge ref_clk) begin
    if (reset || base_cnt == 16'(BASE_DIV - 1)) begin
      base_cnt <= tone_pkg::WORD_RESET;
    end else begin
      base_cnt <= base_cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || fsk_cnt == 16'(FSK_DIV - 1)) begin
      fsk_cnt <= tone_pkg::WORD_RESET;
    end else begin
      fsk_cnt <= fsk_cnt + 16'h0001;
    end
  end

  assign base_tick = (base_cnt == 16'(BASE_DIV - 1));
  assign fsk_tick  = (fsk_cnt == 16'(FSK_DIV - 1));
  assign fast_mode = enhanced_fsk_on
                   && ctrl[tone_pkg::GEN_A][tone_pkg::CTRL_REFRESH];
  assign tick[tone_pkg::GEN_A] = fast_mode ? fsk_tick : base_tick;
  assign tick[tone_pkg::GEN_B] = base_tick;

  // indirect coefficient store
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < tone_pkg::NUM_GEN; i++) begin
        freq_coef[i]  <= tone_pkg::WORD_RESET;
        amp_coef[i]   <= tone_pkg::WORD_RESET;
        phase_coef[i] <= tone_pkg::WORD_RESET;
      end
      mark_freq   <= tone_pkg::WORD_RESET;
      mark_amp    <= tone_pkg::WORD_RESET;
      mark_phase  <= tone_pkg::WORD_RESET;
      space_freq  <= tone_pkg::WORD_RESET;
      space_amp   <= tone_pkg::WORD_RESET;
      space_phase <= tone_pkg::WORD_RESET;
    end else if (reg_wr && reg_addr == tone_pkg::ADDR_IND_WADDR) begin
      for (int i = 0; i < tone_pkg::NUM_GEN; i++) begin
        if (reg_wdata == tone_pkg::IND_FREQ[i]) begin
          freq_coef[i] <= ind_data;
        end
        if (reg_wdata == tone_pkg::IND_AMP[i]) begin
          amp_coef[i] <= ind_data;
        end
        if (reg_wdata == tone_pkg::IND_PHASE[i]) begin
          phase_coef[i] <= ind_data;
        end
      end
      case (reg_wdata)
        tone_pkg::IND_MARK_FREQ:   mark_freq   <= ind_data;
        tone_pkg::IND_MARK_AMP:    mark_amp    <= ind_data;
        tone_pkg::IND_MARK_PHASE:  mark_phase  <= ind_data;
        tone_pkg::IND_SPACE_FREQ:  space_freq  <= ind_data;
        tone_pkg::IND_SPACE_AMP:   space_amp   <= ind_data;
        tone_pkg::IND_SPACE_PHASE: space_phase <= ind_data;
        default: begin
        end
      endcase
    end
  end

  function automatic logic [15:0] ind_read(input logic [7:0] a);
    ind_read = tone_pkg::WORD_RESET;
    for (int i = 0; i < tone_pkg::NUM_GEN; i++) begin
      if (a == tone_pkg::IND_FREQ[i]) begin
        ind_read = freq_coef[i];
      end
      if (a == tone_pkg::IND_AMP[i]) begin
        ind_read = amp_coef[i];
      end
      if (a == tone_pkg::IND_PHASE[i]) begin
        ind_read = phase_coef[i];
      end
    end
    case (a)
      tone_pkg::IND_MARK_FREQ:   ind_read = mark_freq;
      tone_pkg::IND_MARK_AMP:    ind_read = mark_amp;
      tone_pkg::IND_MARK_PHASE:  ind_read = mark_phase;
      tone_pkg::IND_SPACE_FREQ:  ind_read = space_freq;
      tone_pkg::IND_SPACE_AMP:   ind_read = space_amp;
      tone_pkg::IND_SPACE_PHASE: ind_read = space_phase;
      default: begin
      end
    endcase
  endfunction : ind_read

  // indirect data window
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ind_data <= tone_pkg::WORD_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        tone_pkg::ADDR_IND_LO:    ind_data[7:0]  <= reg_wdata;
        tone_pkg::ADDR_IND_HI:    ind_data[15:8] <= reg_wdata;
        tone_pkg::ADDR_IND_RADDR: ind_data       <= ind_read(reg_wdata);
        default: begin
        end
      endcase
    end
  end

  // fsk mode and data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enhanced_fsk_on <= 1'b0;
      fsk_level       <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == tone_pkg::ADDR_FSK_MODE) begin
        enhanced_fsk_on <= reg_wdata[tone_pkg::FSK_MODE_BIT];
      end
      if (reg_addr == tone_pkg::ADDR_FSK_DATA) begin
        fsk_level <= reg_wdata[tone_pkg::FSK_LEVEL_BIT];
      end
    end
  end

  for (genvar g = 0; g < tone_pkg::NUM_GEN; g++) begin : gen_tone
    logic               run;
    logic               on_en;
    logic               off_en;
    logic               cadence;
    logic               refresh;
    logic signed [15:0] step;
    logic               crossed;
    logic [15:0]        next_count;
    logic [15:0]        new_freq;

    assign run     = ctrl[g][tone_pkg::CTRL_RUN];
    assign on_en   = ctrl[g][tone_pkg::CTRL_ON_EN];
    assign off_en  = ctrl[g][tone_pkg::CTRL_OFF_EN];
    assign cadence = on_en && off_en;
    assign refresh = (g == tone_pkg::GEN_A)
                   && ctrl[g][tone_pkg::CTRL_REFRESH];
    assign step    = resonate(wfreq[g], y1[g], y2[g]);
    assign crossed = (step[15] != y1[g][15]) || (step == 16'sh0000);
    assign next_count = count[g] + 16'h0001;
    assign new_freq   = !fast_mode ? freq_coef[g]
                      : (fsk_level ? mark_freq : space_freq);

    assign on_expire[g]  = (state[g] == tone_pkg::ST_ON) && tick[g]
                         && on_en && (count[g] == on_time[g]);
    assign off_expire[g] = (state[g] == tone_pkg::ST_OFF) && tick[g]
                         && (count[g] == off_time[g]);
    assign end_burst[g]  = (on_expire[g] && !refresh
                            && !ctrl[g][tone_pkg::CTRL_ZC])
                         || ((state[g] == tone_pkg::ST_ZERO_WAIT)
                             && tick[g] && crossed);
    assign sample[g] = ((state[g] == tone_pkg::ST_ON)
                     || (state[g] == tone_pkg::ST_ZERO_WAIT))
                     ? y1[g] : 16'sh0000;

    // control register, run bit set by the off timer in cadence, cleared when a burst ends in cadence or one-shot
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        ctrl[g] <= tone_pkg::BYTE_RESET;
      end else if (reg_wr && reg_addr == tone_pkg::ADDR_CTRL[g]) begin
        ctrl[g] <= reg_wdata & ((g == tone_pkg::GEN_A)
                   ? tone_pkg::CTRL_WMASK_A
                   : tone_pkg::CTRL_WMASK_B);
      end else if (off_expire[g]) begin
        ctrl[g][tone_pkg::CTRL_RUN] <= 1'b1;
      end else if (end_burst[g]) begin
        ctrl[g][tone_pkg::CTRL_RUN] <= 1'b0;
      end
    end

    // cadence timers
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        on_time[g]  <= tone_pkg::WORD_RESET;
        off_time[g] <= tone_pkg::WORD_RESET;
      end else if (reg_wr) begin
        if (reg_addr == tone_pkg::ADDR_ON_LO[g]) begin
          on_time[g][7:0] <= reg_wdata;
        end
        if (reg_addr == tone_pkg::ADDR_ON_HI[g]) begin
          on_time[g][15:8] <= reg_wdata;
        end
        if (reg_addr == tone_pkg::ADDR_OFF_LO[g]) begin
          off_time[g][7:0] <= reg_wdata;
        end
        if (reg_addr == tone_pkg::ADDR_OFF_HI[g]) begin
          off_time[g][15:8] <= reg_wdata;
        end
      end
    end

    // cadence sequencer and oscillator
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        state[g] <= tone_pkg::ST_IDLE;
        count[g] <= tone_pkg::WORD_RESET;
        y1[g]    <= 16'sh0000;
        y2[g]    <= 16'sh0000;
        wfreq[g] <= 16'sh0000;
      end else begin
        case (state[g])
          tone_pkg::ST_IDLE: begin
            if (run) begin
              state[g] <= tone_pkg::ST_ON;
              count[g] <= tone_pkg::WORD_RESET;
              wfreq[g] <= freq_coef[g];
              y1[g]    <= phase_coef[g];
              y2[g]    <= -amp_coef[g];
            end
          end
          tone_pkg::ST_ON: begin
            if (!run) begin
              state[g] <= tone_pkg::ST_IDLE;
            end else if (tick[g]) begin
              y1[g]    <= step;
              y2[g]    <= y1[g];
              count[g] <= next_count;
              if (on_expire[g]) begin
                count[g] <= tone_pkg::WORD_RESET;
                if (refresh) begin
                  wfreq[g] <= new_freq;
                end else if (ctrl[g][tone_pkg::CTRL_ZC]) begin
                  state[g] <= tone_pkg::ST_ZERO_WAIT;
                end else if (cadence) begin
                  state[g] <= tone_pkg::ST_OFF;
                end else begin
                  state[g] <= tone_pkg::ST_IDLE;
                end
              end
            end
          end
          tone_pkg::ST_ZERO_WAIT: begin
            if (!run) begin
              state[g] <= tone_pkg::ST_IDLE;
            end else if (tick[g]) begin
              y1[g] <= step;
              y2[g] <= y1[g];
              if (crossed) begin
                count[g] <= tone_pkg::WORD_RESET;
                state[g] <= cadence ? tone_pkg::ST_OFF
                                    : tone_pkg::ST_IDLE;
              end
            end
          end
          tone_pkg::ST_OFF: begin
            if (!cadence) begin
              state[g] <= tone_pkg::ST_IDLE;
            end else if (off_expire[g]) begin
              state[g] <= tone_pkg::ST_ON;
              count[g] <= tone_pkg::WORD_RESET;
              wfreq[g] <= freq_coef[g];
              y1[g]    <= phase_coef[g];
              y2[g]    <= -amp_coef[g];
            end else if (tick[g]) begin
              count[g] <= next_count;
            end
          end
          default: begin
            state[g] <= tone_pkg::ST_IDLE;
          end
        endcase
      end
    end

    assign irq_set[tone_pkg::IRQ_ON[g]]  = on_expire[g];
    assign irq_set[tone_pkg::IRQ_OFF[g]] = off_expire[g];
  end

  // interrupt pending, set wins over write-one-to-clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_pend <= '0;
    end else if (reg_wr && reg_addr == tone_pkg::ADDR_IRQ_PEND) begin
      irq_pend <= (irq_pend & ~reg_wdata[tone_pkg::IRQ_W-1:0])
                | irq_set;
    end else begin
      irq_pend <= irq_pend | irq_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_en <= '0;
    end else if (reg_wr && reg_addr == tone_pkg::ADDR_IRQ_EN) begin
      irq_en <= reg_wdata[tone_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_pend & irq_en);
    end
  end

  // output routing and mixing
  always_ff @(posedge ref_clk) begin
    logic signed [33:0] rx_sum;
    logic signed [33:0] tx_sum;
    rx_sum = '0;
    tx_sum = '0;
    for (int i = 0; i < tone_pkg::NUM_GEN; i++) begin
      if (ctrl[i][tone_pkg::CTRL_RX_BIT]) begin
        rx_sum = rx_sum + 34'(sample[i]);
      end
      if (ctrl[i][tone_pkg::CTRL_TX_BIT]) begin
        tx_sum = tx_sum + 34'(sample[i]);
      end
    end
    if (reset) begin
      rx_tone <= tone_pkg::WORD_RESET;
      tx_tone <= tone_pkg::WORD_RESET;
    end else begin
      rx_tone <= sat16(rx_sum);
      tx_tone <= sat16(tx_sum);
    end
  end

  // register read
  always_ff @(posedge ref_clk) begin
    logic [7:0] rd;
    rd = tone_pkg::BYTE_RESET;
    for (int i = 0; i < tone_pkg::NUM_GEN; i++) begin
      if (reg_addr == tone_pkg::ADDR_CTRL[i]) begin
        rd = ctrl[i];
        rd[tone_pkg::CTRL_LIVE] = (sample[i] != 16'sh0000)
                               || (state[i] == tone_pkg::ST_ON)
                               || (state[i] == tone_pkg::ST_ZERO_WAIT);
      end
      if (reg_addr == tone_pkg::ADDR_ON_LO[i]) begin
        rd = on_time[i][7:0];
      end
      if (reg_addr == tone_pkg::ADDR_ON_HI[i]) begin
        rd = on_time[i][15:8];
      end
      if (reg_addr == tone_pkg::ADDR_OFF_LO[i]) begin
        rd = off_time[i][7:0];
      end
      if (reg_addr == tone_pkg::ADDR_OFF_HI[i]) begin
        rd = off_time[i][15:8];
      end
    end
    case (reg_addr)
      tone_pkg::ADDR_IRQ_PEND: rd = 8'(irq_pend);
      tone_pkg::ADDR_IRQ_EN:   rd = 8'(irq_en);
      tone_pkg::ADDR_IND_LO:   rd = ind_data[7:0];
      tone_pkg::ADDR_IND_HI:   rd = ind_data[15:8];
      tone_pkg::ADDR_FSK_MODE: rd = 8'({enhanced_fsk_on, 6'h00});
      default: begin
      end
    endcase
    if (reset) begin
      reg_rdata <= tone_pkg::BYTE_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rd;
    end
  end

endmodule : dual_tone_cadence_generator

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        irq;
  logic [15:0] rx_tone;
  logic [15:0] tx_tone;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [7:0]  d;
  always #5 ref_clk = ~ref_clk;
  dual_tone_cadence_generator #(.BASE_DIV(20), .FSK_DIV(7))
  u_dual_tone_cadence_generator (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .rx_tone(rx_tone), .tx_tone(tx_tone)
  );
  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [7:0] e);
    rd(a, d);
    chk8(n, e, d);
  endtask : rchk
  task automatic setcoef(input logic [7:0] ia, input logic [15:0] v);
    wr(tone_pkg::ADDR_IND_LO, v[7:0]);
    wr(tone_pkg::ADDR_IND_HI, v[15:8]);
    wr(tone_pkg::ADDR_IND_WADDR, ia);
  endtask : setcoef
  task automatic wait_pend(input int b);
    for (int i = 0; i < 200; i++) begin
      rd(tone_pkg::ADDR_IRQ_PEND, d);
      if (d[b] === 1'b1) break;
    end
    chk8("pending bit", 8'h01, {7'h00, d[b]});
  endtask : wait_pend
  task automatic settime(input int g, input logic [7:0] on,
                         input logic [7:0] off);
    wr(tone_pkg::ADDR_ON_LO[g], on);
    wr(tone_pkg::ADDR_ON_HI[g], 8'h00);
    wr(tone_pkg::ADDR_OFF_LO[g], off);
    wr(tone_pkg::ADDR_OFF_HI[g], 8'h00);
  endtask : settime
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rchk("ctrl a", tone_pkg::ADDR_CTRL[0], 8'h00);
    rchk("pending", tone_pkg::ADDR_IRQ_PEND, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    wr(tone_pkg::ADDR_CTRL[1], 8'h63);
    rchk("ctrl b mask", tone_pkg::ADDR_CTRL[1], 8'h23);
    wr(tone_pkg::ADDR_CTRL[1], 8'h00);
    for (int g = 0; g < 2; g++) begin
      wr(tone_pkg::ADDR_ON_LO[g], 8'hA5 ^ g[7:0]);
      wr(tone_pkg::ADDR_ON_HI[g], 8'h5A ^ g[7:0]);
      wr(tone_pkg::ADDR_OFF_LO[g], 8'hC3 ^ g[7:0]);
      wr(tone_pkg::ADDR_OFF_HI[g], 8'h3C ^ g[7:0]);
    end
    for (int g = 0; g < 2; g++) begin
      rchk("on lo", tone_pkg::ADDR_ON_LO[g], 8'hA5 ^ g[7:0]);
      rchk("on hi", tone_pkg::ADDR_ON_HI[g], 8'h5A ^ g[7:0]);
      rchk("off lo", tone_pkg::ADDR_OFF_LO[g], 8'hC3 ^ g[7:0]);
      rchk("off hi", tone_pkg::ADDR_OFF_HI[g], 8'h3C ^ g[7:0]);
    end
    setcoef(tone_pkg::IND_FREQ[0], 16'h6465);
    setcoef(tone_pkg::IND_AMP[0], 16'h0590);
    setcoef(tone_pkg::IND_PHASE[0], 16'h0000);
    wr(tone_pkg::ADDR_IND_RADDR, tone_pkg::IND_AMP[0]);
    rchk("coef lo", tone_pkg::ADDR_IND_LO, 8'h90);
    rchk("coef hi", tone_pkg::ADDR_IND_HI, 8'h05);
    wr(tone_pkg::ADDR_CTRL[0], 8'h05);
    repeat (100) @(posedge ref_clk);
    chk8("rx live", 8'h01, {7'h00, rx_tone != 16'h0000});
    rchk("ctrl a live", tone_pkg::ADDR_CTRL[0], 8'h85);
    wr(tone_pkg::ADDR_CTRL[0], 8'h00);
    repeat (60) @(posedge ref_clk);
    chk8("rx stopped", 8'h00, {7'h00, rx_tone != 16'h0000});
    settime(0, 8'h01, 8'h00);
    settime(1, 8'h02, 8'h00);
    wr(tone_pkg::ADDR_CTRL[0], 8'h1D);
    wait_pend(0);
    chk8("irq masked", 8'h00, {7'h00, irq});
    wr(tone_pkg::ADDR_IRQ_EN, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk8("irq on", 8'h01, {7'h00, irq});
    wait_pend(1);
    wr(tone_pkg::ADDR_CTRL[0], 8'h00);
    wr(tone_pkg::ADDR_IRQ_PEND, 8'h0F);
    repeat (3) @(posedge ref_clk);
    chk8("irq cleared", 8'h00, {7'h00, irq});
    wr(tone_pkg::ADDR_IRQ_EN, 8'h00);
    wr(tone_pkg::ADDR_CTRL[1], 8'h15);
    wait_pend(2);
    repeat (5) @(posedge ref_clk);
    rchk("ctrl b shot", tone_pkg::ADDR_CTRL[1], 8'h11);
    rchk("pending b", tone_pkg::ADDR_IRQ_PEND, 8'h04);
    wr(tone_pkg::ADDR_CTRL[0], 8'h06);
    repeat (100) @(posedge ref_clk);
    chk8("tx live", 8'h01, {7'h00, tx_tone != 16'h0000});
    chk8("rx unrouted", 8'h00, {7'h00, rx_tone != 16'h0000});
    wr(tone_pkg::ADDR_CTRL[0], 8'h00);
    wr(tone_pkg::ADDR_IRQ_PEND, 8'h0F);
    wr(tone_pkg::ADDR_CTRL[0], 8'h35);
    wait_pend(0);
    repeat (200) @(posedge ref_clk);
    rchk("ctrl a zc end", tone_pkg::ADDR_CTRL[0], 8'h31);
    wr(tone_pkg::ADDR_IRQ_PEND, 8'h0F);
    setcoef(tone_pkg::IND_MARK_FREQ, 16'h3FC4);
    wr(tone_pkg::ADDR_IND_RADDR, tone_pkg::IND_MARK_FREQ);
    rchk("mark lo", tone_pkg::ADDR_IND_LO, 8'hC4);
    rchk("mark hi", tone_pkg::ADDR_IND_HI, 8'h3F);
    wr(tone_pkg::ADDR_FSK_MODE, 8'h40);
    rchk("fsk mode", tone_pkg::ADDR_FSK_MODE, 8'h40);
    wr(tone_pkg::ADDR_FSK_DATA, 8'h01);
    wr(tone_pkg::ADDR_CTRL[0], 8'h55);
    wait_pend(0);
    repeat (20) @(posedge ref_clk);
    rchk("ctrl a refresh", tone_pkg::ADDR_CTRL[0], 8'hD5);
    wr(tone_pkg::ADDR_CTRL[0], 8'h00);
    wr(tone_pkg::ADDR_FSK_MODE, 8'h00);
    give_verdict();
  end
endmodule : tb_top

//--- tb/tone_checker_asserts.sv
`timescale 1ns/100ps
module tone_checker_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // outputs
  input wire logic        irq,
  input wire logic [15:0] rx_tone,
  input wire logic [15:0] tx_tone
);
  logic [7:0] en_q;
  logic [7:0] ca_q;
  logic [7:0] cb_q;
  logic       tx_used;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // shadows of software-owned bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      en_q <= 8'h00;
      ca_q <= 8'h00;
      cb_q <= 8'h00;
      tx_used <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == tone_pkg::ADDR_IRQ_EN) en_q <= reg_wdata;
      if (reg_addr == tone_pkg::ADDR_CTRL[0]) ca_q <= reg_wdata;
      if (reg_addr == tone_pkg::ADDR_CTRL[1]) cb_q <= reg_wdata;
      if (reg_addr[7:1] == 7'h10 && reg_wdata[1]) tx_used <= 1'b1;
    end
  end
  sequence s_rd_a;
    reg_rd && !reg_wr && reg_addr == tone_pkg::ADDR_CTRL[0];
  endsequence
  sequence s_rd_b;
    reg_rd && !reg_wr && reg_addr == tone_pkg::ADDR_CTRL[1];
  endsequence
  a_reset_quiet: assert property (
    $fell(reset) |-> !irq && rx_tone == 16'h0000 && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  a_rdata_hold: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (
    reg_rd && !reg_wr && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_needs_en: assert property (
    en_q[3:0] == 4'h0 && $past(en_q[3:0], 2) == 4'h0 |-> !irq)
    else $error("interrupt without enable");
  a_en_readback: assert property (
    reg_rd && !reg_wr && reg_addr == tone_pkg::ADDR_IRQ_EN
    |=> reg_rdata[3:0] == $past(en_q[3:0]))
    else $error("enable readback wrong");
  a_ctla_readback: assert property (
    s_rd_a |=> reg_rdata[6:3] == $past(ca_q[6:3])
    && reg_rdata[1:0] == $past(ca_q[1:0]))
    else $error("control a readback wrong");
  a_ctlb_readback: assert property (
    s_rd_b |=> !reg_rdata[6] && reg_rdata[5:3] == $past(cb_q[5:3])
    && reg_rdata[1:0] == $past(cb_q[1:0]))
    else $error("control b readback wrong");
  a_tx_silent: assert property (
    !tx_used |-> tx_tone == 16'h0000)
    else $error("transmit tone without routing");
endmodule : tone_checker_asserts

bind dual_tone_cadence_generator tone_checker_asserts u_tone_checker_asserts (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .rx_tone(rx_tone), .tx_tone(tx_tone)
);
